// ==== core/i2ci_pkg.sv ====
// Constants shared by the two-wire event interrupt enable block.
// Assumes a 16-bit register port and a single core clock.
package i2ci_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_IEN = 8'h02;
  localparam logic [7:0] OFS_STAT = 8'h03;
  localparam logic [7:0] OFS_CTRL = 8'h06;
  localparam logic [7:0] OFS_PEND = 8'h07;

  // ****************************************
  // Event bit positions (enable, status, pending)
  // ****************************************
  localparam int BIT_START = 0;
  localparam int BIT_TXDONE = 1;
  localparam int BIT_RXRDY = 2;
  localparam int BIT_STRETCH = 3;
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_ADDRMATCH = 5;
  localparam int BIT_ARBLOST = 6;
  localparam int BIT_NACK = 7;
  localparam int BIT_GENCALL = 8;
  localparam int BIT_OVERRUN = 9;
  localparam int BIT_STOP = 11;

  // Control register field
  localparam int BIT_GC_RESP = 0;

  // ****************************************
  // Masks and reset values
  // ****************************************
  localparam logic [15:0] EVT_MASK = 16'h0bff;
  localparam logic [15:0] CTRL_MASK = 16'h0001;
  localparam logic [15:0] IEN_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] RDATA_RST = 16'h0000;

  // ****************************************
  // Receive holding state
  // ****************************************
  typedef enum logic [0:0] {
    RX_EMPTY = 1'b0,
    RX_HELD = 1'b1
  } i2ci_rx_state_t;

endpackage

// ==== core/i2ci_flag_cell.sv ====
// One sticky event flag: set by a hardware pulse, cleared by software.
// Assumes set and clear are single-cycle pulses on core_clk.
`timescale 1ns/1ps

module i2ci_flag_cell (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic set_pulse,
  input wire logic clr_pulse,
  output logic flag
);

  typedef struct packed {
    logic flag;
  } i2ci_cell_state_t;

  i2ci_cell_state_t state_reg;
  i2ci_cell_state_t state_next;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    // Set wins over a clear in the same cycle
    state_next.flag = set_pulse | (state_reg.flag & ~clr_pulse);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flag = state_reg.flag;

endmodule

// ==== core/i2ci_rx_overrun.sv ====
// Receive overrun detector: tracks one unread received byte.
// Assumes arrival and buffer read are single-cycle pulses on core_clk.
`timescale 1ns/1ps

module i2ci_rx_overrun (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic byte_arrive,
  input wire logic buffer_read,
  output logic overrun_flag
);

  typedef struct packed {
    i2ci_pkg::i2ci_rx_state_t held;
    logic ovr;
  } i2ci_ovr_state_t;

  i2ci_ovr_state_t state_reg;
  i2ci_ovr_state_t state_next;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    if (buffer_read) begin
      // Read takes the held byte; a byte arriving now becomes the held one
      state_next.ovr = 1'b0;
      state_next.held = byte_arrive ? i2ci_pkg::RX_HELD : i2ci_pkg::RX_EMPTY;
    end else if (byte_arrive) begin
      case (state_reg.held)
        i2ci_pkg::RX_HELD: begin
          state_next.ovr = 1'b1;
        end
        default: begin
          state_next.held = i2ci_pkg::RX_HELD;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{held: i2ci_pkg::RX_EMPTY, ovr: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign overrun_flag = state_reg.ovr;

endmodule

// ==== core/i2ci_event_irq.sv ====
// Two-wire controller event interrupt enable and flag block.
// Assumes event inputs are one-cycle pulses from the controller status
// logic, synchronous to core_clk, and a one-clock register port.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps

module i2ci_event_irq (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic start_detect_evt,
  input wire logic transmit_done_evt,
  input wire logic receive_ready_evt,
  input wire logic clock_stretch_evt,
  input wire logic timeout_evt,
  input wire logic address_match_evt,
  input wire logic arbitration_lost_evt,
  input wire logic not_ack_evt,
  input wire logic general_call_evt,
  input wire logic stop_detect_evt,
  input wire logic rx_byte_arrive,
  input wire logic rx_buffer_read,
  output logic i2c_irq,
  output logic clock_stretch_flag,
  output logic receive_overrun_flag,
  output logic general_call_response_en
);

  // ****************************************
  // Helpers
  // ****************************************

  // Address match for the register port
  function automatic logic reg_hit(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    reg_hit = (addr == ofs);
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] ien;
    logic [15:0] ctrl;
    logic [15:0] rdata;
  } i2ci_top_state_t;

  i2ci_top_state_t state_reg;
  i2ci_top_state_t state_next;

  logic [15:0] evt_vec;
  logic [15:0] clr_vec;
  logic [15:0] flag_vec;
  logic [15:0] pend_vec;
  logic wr_ien;
  logic wr_stat;
  logic wr_ctrl;
  logic rd_ien;
  logic rd_stat;
  logic rd_ctrl;
  logic rd_pend;

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    wr_ien = 1'b0;
    wr_stat = 1'b0;
    wr_ctrl = 1'b0;
    if (!reg_wr) begin
      wr_ien = 1'b0;
    end else if (reg_hit(reg_addr, i2ci_pkg::OFS_IEN)) begin
      wr_ien = 1'b1;
    end else if (reg_hit(reg_addr, i2ci_pkg::OFS_STAT)) begin
      wr_stat = 1'b1;
    end else if (reg_hit(reg_addr, i2ci_pkg::OFS_CTRL)) begin
      wr_ctrl = 1'b1;
    end
  end

  always_comb begin
    rd_ien = 1'b0;
    rd_stat = 1'b0;
    rd_ctrl = 1'b0;
    rd_pend = 1'b0;
    if (!reg_rd) begin
      rd_ien = 1'b0;
    end else if (reg_hit(reg_addr, i2ci_pkg::OFS_IEN)) begin
      rd_ien = 1'b1;
    end else if (reg_hit(reg_addr, i2ci_pkg::OFS_STAT)) begin
      rd_stat = 1'b1;
    end else if (reg_hit(reg_addr, i2ci_pkg::OFS_CTRL)) begin
      rd_ctrl = 1'b1;
    end else if (reg_hit(reg_addr, i2ci_pkg::OFS_PEND)) begin
      rd_pend = 1'b1;
    end
  end

  // ****************************************
  // Event collection
  // ****************************************
  always_comb begin
    evt_vec = 16'h0000;
    evt_vec[i2ci_pkg::BIT_START] = start_detect_evt;
    evt_vec[i2ci_pkg::BIT_TXDONE] = transmit_done_evt;
    evt_vec[i2ci_pkg::BIT_RXRDY] = receive_ready_evt;
    evt_vec[i2ci_pkg::BIT_STRETCH] = clock_stretch_evt;
    evt_vec[i2ci_pkg::BIT_TIMEOUT] = timeout_evt;
    evt_vec[i2ci_pkg::BIT_ADDRMATCH] = address_match_evt;
    evt_vec[i2ci_pkg::BIT_ARBLOST] = arbitration_lost_evt;
    evt_vec[i2ci_pkg::BIT_NACK] = not_ack_evt;
    // General call only counts while response is enabled
    evt_vec[i2ci_pkg::BIT_GENCALL] = general_call_evt &
      state_reg.ctrl[i2ci_pkg::BIT_GC_RESP];
    evt_vec[i2ci_pkg::BIT_STOP] = stop_detect_evt;
  end

  // Write one to clear; overrun bit ignores writes
  always_comb begin
    clr_vec = 16'h0000;
    if (wr_stat) begin
      clr_vec = reg_wdata & i2ci_pkg::EVT_MASK;
    end
    clr_vec[i2ci_pkg::BIT_OVERRUN] = 1'b0;
  end

  // ****************************************
  // Sticky event flags
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      if (gi == i2ci_pkg::BIT_OVERRUN) begin : g_ovr
        i2ci_rx_overrun u_ovr (
          .core_clk(core_clk),
          .rst_n(rst_n),
          .byte_arrive(rx_byte_arrive),
          .buffer_read(rx_buffer_read),
          .overrun_flag(flag_vec[gi])
        );
      end else if (i2ci_pkg::EVT_MASK[gi]) begin : g_cell
        i2ci_flag_cell u_cell (
          .core_clk(core_clk),
          .rst_n(rst_n),
          .set_pulse(evt_vec[gi]),
          .clr_pulse(clr_vec[gi]),
          .flag(flag_vec[gi])
        );
      end else begin : g_none
        assign flag_vec[gi] = 1'b0;
      end
    end
  endgenerate

  // ****************************************
  // Gating and request
  // ****************************************

  // Each enable bit gates only its own flag
  always_comb begin
    pend_vec = 16'h0000;
    pend_vec[i2ci_pkg::BIT_START] = flag_vec[i2ci_pkg::BIT_START] &
      state_reg.ien[i2ci_pkg::BIT_START];
    pend_vec[i2ci_pkg::BIT_TXDONE] = flag_vec[i2ci_pkg::BIT_TXDONE] &
      state_reg.ien[i2ci_pkg::BIT_TXDONE];
    pend_vec[i2ci_pkg::BIT_RXRDY] = flag_vec[i2ci_pkg::BIT_RXRDY] &
      state_reg.ien[i2ci_pkg::BIT_RXRDY];
    pend_vec[i2ci_pkg::BIT_STRETCH] = flag_vec[i2ci_pkg::BIT_STRETCH] &
      state_reg.ien[i2ci_pkg::BIT_STRETCH];
    pend_vec[i2ci_pkg::BIT_TIMEOUT] = flag_vec[i2ci_pkg::BIT_TIMEOUT] &
      state_reg.ien[i2ci_pkg::BIT_TIMEOUT];
    pend_vec[i2ci_pkg::BIT_ADDRMATCH] = flag_vec[i2ci_pkg::BIT_ADDRMATCH] &
      state_reg.ien[i2ci_pkg::BIT_ADDRMATCH];
    pend_vec[i2ci_pkg::BIT_ARBLOST] = flag_vec[i2ci_pkg::BIT_ARBLOST] &
      state_reg.ien[i2ci_pkg::BIT_ARBLOST];
    pend_vec[i2ci_pkg::BIT_NACK] = flag_vec[i2ci_pkg::BIT_NACK] &
      state_reg.ien[i2ci_pkg::BIT_NACK];
    pend_vec[i2ci_pkg::BIT_GENCALL] = flag_vec[i2ci_pkg::BIT_GENCALL] &
      state_reg.ien[i2ci_pkg::BIT_GENCALL];
    pend_vec[i2ci_pkg::BIT_OVERRUN] = flag_vec[i2ci_pkg::BIT_OVERRUN] &
      state_reg.ien[i2ci_pkg::BIT_OVERRUN];
    pend_vec[i2ci_pkg::BIT_STOP] = flag_vec[i2ci_pkg::BIT_STOP] &
      state_reg.ien[i2ci_pkg::BIT_STOP];
  end

  // Level request while any enabled flag stays set
  assign i2c_irq = |pend_vec;

  // ****************************************
  // Register next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    if (wr_ien) begin
      // Unused bits never store a one
      state_next.ien = reg_wdata & i2ci_pkg::EVT_MASK;
    end
    if (wr_ctrl) begin
      state_next.ctrl = reg_wdata & i2ci_pkg::CTRL_MASK;
    end
    // Read data stand for one cycle only
    state_next.rdata = 16'h0000;
    if (rd_ien) begin
      state_next.rdata = state_reg.ien & i2ci_pkg::EVT_MASK;
    end else if (rd_stat) begin
      state_next.rdata = flag_vec & i2ci_pkg::EVT_MASK;
    end else if (rd_ctrl) begin
      state_next.rdata = state_reg.ctrl & i2ci_pkg::CTRL_MASK;
    end else if (rd_pend) begin
      state_next.rdata = pend_vec;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.ien <= i2ci_pkg::IEN_RST;
      state_reg.ctrl <= i2ci_pkg::CTRL_RST;
      state_reg.rdata <= i2ci_pkg::RDATA_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = state_reg.rdata;
  assign clock_stretch_flag = flag_vec[i2ci_pkg::BIT_STRETCH];
  assign receive_overrun_flag = flag_vec[i2ci_pkg::BIT_OVERRUN];
  assign general_call_response_en = state_reg.ctrl[i2ci_pkg::BIT_GC_RESP];

endmodule

// ==== testbench/i2ci_event_irq_asserts.sv ====
// Port-level checker for the event interrupt block.
// Assumes it is bound into the block top by the bench.
`timescale 1ns/1ps

module i2ci_event_irq_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic clock_stretch_evt,
  input wire logic rx_byte_arrive,
  input wire logic rx_buffer_read,
  input wire logic i2c_irq,
  input wire logic clock_stretch_flag,
  input wire logic receive_overrun_flag,
  input wire logic general_call_response_en
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Sequences
  // ****************************************
  sequence two_arrivals;
    rx_byte_arrive && !rx_buffer_read ##1 rx_byte_arrive && !rx_buffer_read;
  endsequence

  sequence stretch_enabled;
    reg_wr && reg_addr == 8'h02 && reg_wdata[3] ##1 clock_stretch_flag;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  rsvd_zero_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h02 |-> (reg_rdata & 16'hf400) == 16'h0000)
    else $error("reserved enable bits read nonzero");
  stretch_set_a: assert property (clock_stretch_evt |=> clock_stretch_flag)
    else $error("stretch flag not set");
  stretch_hold_a: assert property (
    clock_stretch_flag && !(reg_wr && reg_addr == 8'h03 && reg_wdata[3]) |=> clock_stretch_flag)
    else $error("stretch flag lost");
  stretch_irq_a: assert property (stretch_enabled |-> i2c_irq)
    else $error("enabled stretch flag gives no request");
  ien_zero_a: assert property (
    reg_wr && reg_addr == 8'h02 && reg_wdata == 16'h0000 |=> !i2c_irq)
    else $error("request with all enables clear");
  overrun_set_a: assert property (two_arrivals |=> receive_overrun_flag)
    else $error("overrun not set");
  overrun_hold_a: assert property (
    receive_overrun_flag && !rx_buffer_read |=> receive_overrun_flag)
    else $error("overrun cleared without buffer read");
  overrun_clr_a: assert property (rx_buffer_read |=> !receive_overrun_flag)
    else $error("overrun kept after buffer read");
  gc_write_a: assert property (
    reg_wr && reg_addr == 8'h06 |=> general_call_response_en == $past(reg_wdata[0]))
    else $error("control write not taken");
  ctrl_read_a: assert property (
    reg_rd && reg_addr == 8'h06 |=> reg_rdata == {15'h0, general_call_response_en})
    else $error("control read wrong");
endmodule

// ==== testbench/i2ci_cpu_model.sv ====
// CPU interrupt input model: counts entries on a rising request.
// Assumes the request is a level synchronous to core_clk.
`timescale 1ns/1ps

module i2ci_cpu_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic i2c_irq,
  output logic [7:0] entries
);
  logic last_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_reg <= 1'b0;
      entries <= 8'h00;
    end else begin
      last_reg <= i2c_irq;
      if (i2c_irq && !last_reg) begin
        entries <= entries + 8'h01;
      end
    end
  end
endmodule

// ==== testbench/i2c_interrupt_enable_mask_bench.sv ====
// Self-checking bench for the event interrupt block.
// Assumes the checker and CPU model files are compiled first.
`timescale 1ns/1ps

module i2c_interrupt_enable_mask_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] ev = 12'h000;
  logic arrive = 1'b0;
  logic bread = 1'b0;
  logic [15:0] reg_rdata;
  logic i2c_irq;
  logic stretch;
  logic overrun;
  logic gc_en;
  logic [7:0] entries;
  logic [15:0] d;
  logic [15:0] en;
  logic [15:0] ex;
  logic [11:0] e;
  logic g;
  int seed = 32'hcca7473f;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  always #10 core_clk = ~core_clk;

  i2ci_event_irq DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .start_detect_evt(ev[0]), .transmit_done_evt(ev[1]), .receive_ready_evt(ev[2]),
    .clock_stretch_evt(ev[3]), .timeout_evt(ev[4]), .address_match_evt(ev[5]),
    .arbitration_lost_evt(ev[6]), .not_ack_evt(ev[7]), .general_call_evt(ev[8]),
    .stop_detect_evt(ev[11]), .rx_byte_arrive(arrive), .rx_buffer_read(bread),
    .i2c_irq(i2c_irq), .clock_stretch_flag(stretch), .receive_overrun_flag(overrun),
    .general_call_response_en(gc_en));

  i2ci_cpu_model cpu (.core_clk(core_clk), .rst_n(rst_n), .i2c_irq(i2c_irq),
    .entries(entries));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic pulse(input logic [11:0] p, input logic ar, input logic br);
    @(posedge core_clk);
    ev <= p;
    arrive <= ar;
    bread <= br;
    @(posedge core_clk);
    ev <= 12'h000;
    arrive <= 1'b0;
    bread <= 1'b0;
    #1;
  endtask

  function automatic logic [15:0] pend(logic [11:0] p, logic [15:0] m, logic gce);
    logic [11:0] q;
    q = gce ? p : (p & 12'heff);
    return {4'h0, q} & m & 16'h0bff;
  endfunction

  task automatic finish_test();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      finish_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h02, d);
    chk("ien_reset", d, 16'h0000);
    wr(8'h02, 16'hffff);
    rd(8'h02, d);
    chk("ien_reserved", d, 16'h0bff);
    rd(8'h40, d);
    chk("unmapped", d, 16'h0000);
    wr(8'h02, 16'h0000);
    pulse(12'h008, 1'b0, 1'b0);
    chk("stretch_masked", {15'h0, i2c_irq}, 16'h0000);
    chk("stretch_flag", {15'h0, stretch}, 16'h0001);
    wr(8'h02, 16'h0008);
    chk("stretch_irq", {15'h0, i2c_irq}, 16'h0001);
    wr(8'h02, 16'h0bf7);
    chk("others_only", {15'h0, i2c_irq}, 16'h0000);
    wr(8'h02, 16'h0000);
    wr(8'h03, 16'hffff);
    wr(8'h06, 16'h0000);
    wr(8'h02, 16'h0100);
    pulse(12'h100, 1'b0, 1'b0);
    chk("gc_refused", {15'h0, i2c_irq}, 16'h0000);
    wr(8'h02, 16'h0200);
    @(posedge core_clk);
    arrive <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    arrive <= 1'b0;
    #1;
    chk("overrun_set", {15'h0, overrun}, 16'h0001);
    chk("overrun_irq", {15'h0, i2c_irq}, 16'h0001);
    wr(8'h03, 16'hffff);
    chk("overrun_w1c", {15'h0, overrun}, 16'h0001);
    pulse(12'h000, 1'b0, 1'b1);
    chk("overrun_read", {15'h0, overrun}, 16'h0000);
    @(posedge core_clk);
    ev <= 12'h010;
    reg_addr <= 8'h03;
    reg_wdata <= 16'h0010;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    ev <= 12'h000;
    reg_wr <= 1'b0;
    #1;
    rd(8'h03, d);
    chk("set_wins", d, 16'h0010);
    wr(8'h03, 16'hffff);
    rd(8'h03, d);
    chk("status_clear", d, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      en = 16'($random(seed));
      g = 1'($random(seed));
      e = 12'($random(seed)) & 12'h9ff;
      if (i == 0) begin
        e = 12'h9ff;
        en = 16'h0bff;
        g = 1'b1;
      end
      wr(8'h02, en);
      wr(8'h06, {15'h0, g});
      rd(8'h06, d);
      chk("ctrl", d, {15'h0, g});
      chk("gc_en", {15'h0, gc_en}, {15'h0, g});
      pulse(e, 1'b0, 1'b0);
      ex = pend(e, en, g);
      rd(8'h03, d);
      chk("status", d, pend(e, 16'hffff, g));
      chk("irq", {15'h0, i2c_irq}, {15'h0, |ex});
      rd(8'h07, d);
      chk("pending", d, ex);
      wr(8'h03, 16'hffff);
      chk("irq_cleared", {15'h0, i2c_irq}, 16'h0000);
    end
    chk("cpu_entries", {15'h0, entries != 8'h00}, 16'h0001);
    finish_test();
  end
endmodule

bind i2ci_event_irq i2ci_event_irq_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .clock_stretch_evt(clock_stretch_evt),
  .rx_byte_arrive(rx_byte_arrive), .rx_buffer_read(rx_buffer_read), .i2c_irq(i2c_irq),
  .clock_stretch_flag(clock_stretch_flag), .receive_overrun_flag(receive_overrun_flag),
  .general_call_response_en(general_call_response_en));
